// [serial_flash_read_path.sv]
// read-command front end of a serial flash with wishbone control
// Overview of operation
// - standard read: opcode, 24-bit address, single lane
// - opcode and address sampled on clock rise
// - data out msb first on falling edges
// - address advances by one per byte
// - select high ends command, lanes released
// - reads ignored while busy cycle runs
// - fast read: eight dummy clocks, lane undriven
// - dual output read after eight dummy clocks
// - quad output read needs quad enable
// - dual io: address two bits, four dummies
// - quad io read needs quad enable
// - wrap setup: 24 dummy bits, wrap byte
// - wrap disable bit zero enables wrapping
// - length field selects 8/16/32/64 bytes
// - wrapped output stays inside aligned section
// - wrap setting applies to later quad io
// - reset forces wrap disabled
// - dual lanes: high bit on lane one
// - quad lanes: nibble bit n on lane n
// - quad address as six nibbles, mode two
// - wrap bits on quad lanes, second-last clock
`timescale 1ns/1ps
module serial_flash_read_path (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // serial link pins
  input wire logic sclk_i,
  input wire logic cs_n_i,
  input wire logic [3:0] lane_pin_i,
  output logic [3:0] lane_pin_o,
  output logic [3:0] lane_oe_n_o,
  // array side
  input wire logic busy_i,
  input wire logic [7:0] mem_data_i,
  output logic mem_rd_o,
  output logic [flash_read_pkg::ADDR_BITS-1:0] mem_addr_o
);
  import flash_read_pkg::*;

  typedef enum logic [2:0] {ST_OPC, ST_ADDR, ST_DUMMY, ST_DATA, ST_WRAP, ST_IGN} state_e;

  state_e state_r;
  logic [5:0] link_q;
  logic sclk_d_r;
  logic rise;
  logic fall;
  logic cs_act;
  logic [3:0] lane_q;
  logic [4:0] cnt_r;
  logic [23:0] sh_in_r;
  logic [7:0] opc_r;
  logic [23:0] addr_r;
  logic fetch_r;
  logic [7:0] fetched_r;
  logic [2:0] beat_r;
  logic [7:0] out_sh_r;
  logic qe_r;
  logic srst_r;
  logic wrap_dis_r;
  logic [1:0] wrap_len_r;
  logic ignored_r;
  logic wb_req;
  logic [7:0] op_now;
  logic [23:0] addr_now;
  logic [2:0] beat_last;

  function automatic logic [2:0] in_lanes(input logic [7:0] op);
    if (op == OP_DUAL_IO) return 3'h2;
    if (op == OP_QUAD_IO || op == OP_WRAP_SET) return 3'h4;
    return 3'h1;
  endfunction : in_lanes

  function automatic logic [2:0] out_lanes(input logic [7:0] op);
    if (op == OP_DUAL_OUT || op == OP_DUAL_IO) return 3'h2;
    if (op == OP_QUAD_OUT || op == OP_QUAD_IO) return 3'h4;
    return 3'h1;
  endfunction : out_lanes

  function automatic logic [3:0] dummy_clocks(input logic [7:0] op);
    if (op == OP_READ) return 4'h0;
    if (op == OP_DUAL_IO) return DUMMY_DUAL_IO;
    if (op == OP_QUAD_IO) return DUMMY_QUAD_IO;
    return DUMMY_FAST;
  endfunction : dummy_clocks

  function automatic logic is_read(input logic [7:0] op);
    return op == OP_READ || op == OP_FAST || op == OP_DUAL_OUT || op == OP_QUAD_OUT
      || op == OP_DUAL_IO || op == OP_QUAD_IO;
  endfunction : is_read

  // msb-first shift by one, two or four lanes
  function automatic logic [23:0] shift_in(input logic [23:0] sh, input logic [3:0] ln,
                                           input logic [2:0] w);
    case (w)
      3'h2: return {sh[21:0], ln[1:0]};
      3'h4: return {sh[19:0], ln[3:0]};
      default: return {sh[22:0], ln[0]};
    endcase
  endfunction : shift_in

  // last clock index of the 24-bit address phase
  function automatic logic [4:0] addr_last(input logic [2:0] w);
    case (w)
      3'h2: return 5'h0B;
      3'h4: return 5'h05;
      default: return 5'h17;
    endcase
  endfunction : addr_last

  function automatic logic [23:0] next_addr(input logic [23:0] a, input logic wrap_on,
                                            input logic [1:0] len);
    logic [23:0] inc;
    logic [23:0] m;
    inc = a + 24'h000001;
    m = (WRAP_MIN_SECTION << len) - 24'h000001;
    return wrap_on ? ((a & ~m) | (inc & m)) : inc;
  endfunction : next_addr

  pin_sync #(.W(6)) link_sync (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .d_i({sclk_i, cs_n_i, lane_pin_i}),
    .q_o(link_q)
  );

  assign lane_q = link_q[3:0];
  assign cs_act = ~link_q[4];
  assign rise = cs_act & link_q[5] & ~sclk_d_r;
  assign fall = cs_act & ~link_q[5] & sclk_d_r;
  assign op_now = {sh_in_r[6:0], lane_q[0]};
  assign addr_now = shift_in(sh_in_r, lane_q, in_lanes(opc_r));
  assign beat_last = 3'h7 >> (out_lanes(opc_r) >> 1);
  assign wb_req = wb_cyc_i & wb_stb_i;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sclk_d_r <= 1'b1; // matches synchroniser reset level, so no false rise
    end else begin
      sclk_d_r <= link_q[5];
    end
  end

  // command sequencer; select high aborts from any state
  always_ff @(posedge clk_i) begin
    if (rst_i || !cs_act) begin
      state_r <= ST_OPC;
      cnt_r <= 5'h00;
      sh_in_r <= 24'h000000;
      fetch_r <= 1'b0;
      if (rst_i) begin
        opc_r <= 8'h00;
        addr_r <= 24'h000000;
        ignored_r <= 1'b0;
      end
    end else begin
      fetch_r <= 1'b0;
      if (rise) begin
        unique case (state_r)
          ST_OPC: begin
            sh_in_r <= shift_in(sh_in_r, lane_q, 3'h1);
            cnt_r <= cnt_r + 5'h01;
            if (cnt_r == OPCODE_LAST) begin
              opc_r <= op_now;
              cnt_r <= 5'h00;
              sh_in_r <= 24'h000000;
              ignored_r <= 1'b0;
              if (op_now == OP_WRAP_SET) begin
                state_r <= ST_WRAP;
              end else if (!is_read(op_now) || busy_i) begin
                state_r <= ST_IGN;
                ignored_r <= is_read(op_now);
              end else if ((op_now == OP_QUAD_OUT || op_now == OP_QUAD_IO) && !qe_r) begin
                state_r <= ST_IGN;
                ignored_r <= 1'b1;
              end else begin
                state_r <= ST_ADDR;
              end
            end
          end
          ST_ADDR: begin
            sh_in_r <= addr_now;
            cnt_r <= cnt_r + 5'h01;
            if (cnt_r == addr_last(in_lanes(opc_r))) begin
              addr_r <= addr_now;
              cnt_r <= 5'h00;
              if (dummy_clocks(opc_r) == 4'h0) begin
                state_r <= ST_DATA;
                fetch_r <= 1'b1;
              end else begin
                state_r <= ST_DUMMY;
              end
            end
          end
          ST_DUMMY: begin
            // mode byte and dummy input are don't care
            cnt_r <= cnt_r + 5'h01;
            if (cnt_r[3:0] == dummy_clocks(opc_r) - 4'h1) begin
              state_r <= ST_DATA;
              fetch_r <= 1'b1;
            end
          end
          ST_WRAP: begin
            cnt_r <= cnt_r + 5'h01;
            if (cnt_r == WRAP_LAST_CLOCK) begin
              state_r <= ST_IGN;
            end
          end
          ST_DATA, ST_IGN: begin
          end
        endcase
      end else if (fall && state_r == ST_DATA && beat_r == beat_last) begin
        // wrap only for quad io, per stored setting
        addr_r <= next_addr(addr_r, !wrap_dis_r && opc_r == OP_QUAD_IO, wrap_len_r);
        fetch_r <= 1'b1;
      end
    end
  end

  // array fetch; byte taken at the edge that ends the strobe cycle
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      mem_rd_o <= 1'b0;
      mem_addr_o <= 24'h000000;
      fetched_r <= 8'h00;
    end else begin
      mem_rd_o <= fetch_r;
      if (fetch_r) begin
        mem_addr_o <= addr_r;
      end
      if (mem_rd_o) begin
        fetched_r <= mem_data_i;
      end
    end
  end

  // output shifter; lanes float except while data is driven
  always_ff @(posedge clk_i) begin
    if (rst_i || !cs_act) begin
      lane_pin_o <= 4'h0;
      lane_oe_n_o <= 4'hF;
      beat_r <= 3'h0;
      out_sh_r <= 8'h00;
    end else if (fall && state_r == ST_DATA) begin
      logic [7:0] sh;
      sh = (beat_r == 3'h0) ? fetched_r : out_sh_r;
      case (out_lanes(opc_r))
        3'h2: begin
          lane_pin_o <= {2'h0, sh[7:6]};
          lane_oe_n_o <= 4'hC;
          out_sh_r <= {sh[5:0], 2'h0};
        end
        3'h4: begin
          lane_pin_o <= sh[7:4];
          lane_oe_n_o <= 4'h0;
          out_sh_r <= {sh[3:0], 4'h0};
        end
        default: begin
          lane_pin_o <= {2'h0, sh[7], 1'b0};
          lane_oe_n_o <= 4'hD;
          out_sh_r <= {sh[6:0], 1'b0};
        end
      endcase
      beat_r <= (beat_r == beat_last) ? 3'h0 : beat_r + 3'h1;
    end
  end

  // wrap setting; low nibble and top bit of the wrap byte unused
  always_ff @(posedge clk_i) begin
    if (rst_i || srst_r) begin
      wrap_dis_r <= WRAP_DIS_RST;
      wrap_len_r <= WRAP_LEN_RST;
    end else if (rise && state_r == ST_WRAP && cnt_r == WRAP_BITS_CLOCK) begin
      wrap_dis_r <= lane_q[0];
      wrap_len_r <= lane_q[2:1];
    end
  end

  // wishbone slave: ack one cycle after request, write commits with ack
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h00000000;
      qe_r <= QE_RST;
      srst_r <= 1'b0;
    end else begin
      wb_ack_o <= wb_req & ~wb_ack_o;
      srst_r <= 1'b0;
      if (wb_req && !wb_ack_o) begin
        case (wb_adr_i)
          CTRL_OFS: wb_dat_o <= {31'h00000000, qe_r};
          STATUS_OFS: wb_dat_o <= {24'h000000, 1'b0, ignored_r, state_r == ST_DATA,
                                   cs_act, 1'b0, wrap_len_r, wrap_dis_r};
          ADDR_OFS: wb_dat_o <= {8'h00, addr_r};
          default: wb_dat_o <= 32'h00000000;
        endcase
      end
      if (wb_req && wb_ack_o && wb_we_i && wb_sel_i[0] && wb_adr_i == CTRL_OFS) begin
        qe_r <= wb_dat_i[CTRL_QE_BIT];
        srst_r <= wb_dat_i[CTRL_SRST_BIT];
      end
    end
  end

  release_on_cs_a: assert property (@(posedge clk_i) disable iff (rst_i)
    !cs_act |=> lane_oe_n_o == 4'hF)
    else $error("lanes driven after select high");

  busy_ignore_a: assert property (@(posedge clk_i) disable iff (rst_i)
    rise && state_r == ST_OPC && cnt_r == OPCODE_LAST && busy_i && op_now == OP_READ
    |=> state_r == ST_IGN)
    else $error("read accepted while busy");

  quad_gate_a: assert property (@(posedge clk_i) disable iff (rst_i)
    rise && state_r == ST_OPC && cnt_r == OPCODE_LAST && !qe_r && op_now == OP_QUAD_IO
    |=> state_r == ST_IGN)
    else $error("quad read accepted without quad enable");

  dummy_quiet_a: assert property (@(posedge clk_i) disable iff (rst_i)
    state_r inside {ST_OPC, ST_ADDR, ST_DUMMY, ST_WRAP, ST_IGN} |-> lane_oe_n_o == 4'hF)
    else $error("lane driven before data phase");

  fall_change_a: assert property (@(posedge clk_i) disable iff (rst_i)
    cs_act && $past(cs_act) && $changed(lane_pin_o) |-> $past(fall))
    else $error("data changed away from falling edge");

  rise_sample_a: assert property (@(posedge clk_i) disable iff (rst_i)
    cs_act && $past(cs_act) && $changed(sh_in_r) |-> $past(rise))
    else $error("input shifted away from rising edge");

  addr_step_a: assert property (@(posedge clk_i) disable iff (rst_i)
    fall && cs_act && state_r == ST_DATA && beat_r == beat_last && opc_r != OP_QUAD_IO
    |=> addr_r == $past(addr_r) + 24'h000001 ##1 mem_rd_o && mem_addr_o == $past(addr_r))
    else $error("read address not advanced and fetched");

  wrap_bound_a: assert property (@(posedge clk_i) disable iff (rst_i)
    fall && cs_act && state_r == ST_DATA && beat_r == beat_last && opc_r == OP_QUAD_IO
    && !wrap_dis_r |=> addr_r[23:6] == $past(addr_r[23:6]) && addr_r[2:0] == $past(addr_r[2:0]) + 3'h1)
    else $error("wrapped address left its section");

  wrap_default_a: assert property (@(posedge clk_i) disable iff (rst_i)
    $fell(rst_i) || $past(srst_r) |-> wrap_dis_r)
    else $error("wrap not disabled after reset");

  wb_ack_a: assert property (@(posedge clk_i) disable iff (rst_i)
    wb_req && !wb_ack_o |=> wb_ack_o ##1 !wb_ack_o)
    else $error("wishbone ack not a single cycle");
endmodule : serial_flash_read_path

// [flash_read_pkg.sv]
// constants shared by the serial flash read path
package flash_read_pkg;
  // opcodes
  localparam logic [7:0] OP_READ = 8'h03;
  localparam logic [7:0] OP_FAST = 8'h0B;
  localparam logic [7:0] OP_DUAL_OUT = 8'h3B;
  localparam logic [7:0] OP_QUAD_OUT = 8'h6B;
  localparam logic [7:0] OP_DUAL_IO = 8'hBB;
  localparam logic [7:0] OP_QUAD_IO = 8'hEB;
  localparam logic [7:0] OP_WRAP_SET = 8'h77;
  // framing counts
  localparam int ADDR_BITS = 24;
  localparam logic [4:0] OPCODE_LAST = 5'h07;
  localparam logic [3:0] DUMMY_FAST = 4'h8;
  localparam logic [3:0] DUMMY_DUAL_IO = 4'h4;
  // mode byte (2 clocks) plus 4 dummy clocks
  localparam logic [3:0] DUMMY_QUAD_IO = 4'h6;
  localparam logic [4:0] WRAP_BITS_CLOCK = 5'h06;
  localparam logic [4:0] WRAP_LAST_CLOCK = 5'h07;
  localparam logic [23:0] WRAP_MIN_SECTION = 24'h000008;
  // register map (byte addresses)
  localparam logic [7:0] CTRL_OFS = 8'h00;
  localparam logic [7:0] STATUS_OFS = 8'h04;
  localparam logic [7:0] ADDR_OFS = 8'h08;
  // field positions
  localparam int CTRL_QE_BIT = 0;
  localparam int CTRL_SRST_BIT = 1;
  // reset values
  localparam logic QE_RST = 1'b0;
  localparam logic WRAP_DIS_RST = 1'b1;
  localparam logic [1:0] WRAP_LEN_RST = 2'h0;
  // synchroniser depth
  localparam int SYNC_STAGES = 3;
endpackage : flash_read_pkg

// [pin_sync.sv]
// three-stage pin synchroniser with agreement filter
`timescale 1ns/1ps
module pin_sync #(
  parameter int W = 1
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // pins in, filtered levels out
  input wire logic [W-1:0] d_i,
  output logic [W-1:0] q_o
);
  logic [W-1:0] s1_r;
  logic [W-1:0] s2_r;
  logic [W-1:0] s3_r;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s1_r <= '1;
      s2_r <= '1;
      s3_r <= '1;
    end else begin
      s1_r <= d_i;
      s2_r <= s1_r;
      s3_r <= s2_r;
    end
  end

  // a bit moves only once stages two and three agree
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      q_o <= '1;
    end else begin
      for (int i = 0; i < W; i++) begin
        if (s2_r[i] == s3_r[i]) begin
          q_o[i] <= s3_r[i];
        end
      end
    end
  end
endmodule : pin_sync

// [flash_host_model.sv]
// host flash controller model: drives clock, select and lanes
`timescale 1ns/1ps
module flash_host_model (
  // clock
  input wire logic clk_i,
  // device side of the lanes
  input wire logic [3:0] dev_lane_i,
  input wire logic [3:0] dev_oe_n_i,
  // link outputs
  output logic sclk_o,
  output logic cs_n_o,
  output logic [3:0] lane_o
);
  logic [3:0] hv_r = 4'h0;
  logic [3:0] hoe_r = 4'h0;
  logic [3:0] prev_r = 4'h0;
  initial begin
    sclk_o = 1'b0;
    cs_n_o = 1'b1;
  end
  // undriven lanes toggle so a stale value never looks valid
  always_ff @(posedge clk_i) prev_r <= lane_o;
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      lane_o[i] = !dev_oe_n_i[i] ? dev_lane_i[i] : hoe_r[i] ? hv_r[i] : ~prev_r[i];
    end
  end
  task automatic wait_clk(input int n);
    repeat (n) @(posedge clk_i);
  endtask : wait_clk
  // one serial clock; sampled late in the high phase for slack
  task automatic tick(input logic [3:0] v, input logic [3:0] oe, output logic [3:0] r);
    hv_r <= v;
    hoe_r <= oe;
    sclk_o <= 1'b0;
    wait_clk(4);
    sclk_o <= 1'b1;
    wait_clk(3);
    @(negedge clk_i);
    r = lane_o;
    wait_clk(1);
  endtask : tick
  task automatic send(input logic [31:0] val, input int nbits, input int w);
    logic [3:0] r;
    logic [3:0] m;
    m = 4'((1 << w) - 1);
    for (int i = 0; i < nbits; i += w) begin
      tick(4'(val >> (32 - w)) & m, m, r);
      val = val << w;
    end
  endtask : send
  task automatic idle(input int n);
    logic [3:0] r;
    repeat (n) tick(4'h0, 4'h0, r);
  endtask : idle
  task automatic recv(input int w, output logic [7:0] b);
    logic [3:0] r;
    for (int i = 0; i < 8; i += w) begin
      tick(4'h0, 4'h0, r);
      b = (b << w) | 8'(w == 1 ? 4'(r[1]) : r & 4'((1 << w) - 1));
    end
  endtask : recv
  task automatic open();
    cs_n_o <= 1'b0;
    wait_clk(4);
  endtask : open
  task automatic close();
    sclk_o <= 1'b0;
    hoe_r <= 4'h0;
    wait_clk(4);
    cs_n_o <= 1'b1;
    wait_clk(12);
  endtask : close
endmodule : flash_host_model

// [serial_flash_read_path_tb_top.sv]
// self-checking bench for the serial flash read path
`timescale 1ns/1ps
module serial_flash_read_path_tb_top;
  import flash_read_pkg::*;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic wb_cyc_i = 1'b0;
  logic wb_stb_i = 1'b0;
  logic wb_we_i = 1'b0;
  logic [7:0] wb_adr_i = 8'h00;
  logic [3:0] wb_sel_i = 4'hF;
  logic [31:0] wb_dat_i = 32'h0;
  logic [31:0] wb_dat_o;
  logic wb_ack_o;
  logic sclk, cs_n, busy_i = 1'b0, mem_rd_o;
  logic [3:0] lane_w, lane_pin_o, lane_oe_n_o;
  logic [7:0] mem_data_i;
  logic [23:0] mem_addr_o;
  logic [31:0] q, seed = 32'hF291;
  int failures = 0;
  int tests_run = 0;
  always #50 clk_i = ~clk_i;
  serial_flash_read_path dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
    .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .sclk_i(sclk),
    .cs_n_i(cs_n), .lane_pin_i(lane_w), .lane_pin_o(lane_pin_o),
    .lane_oe_n_o(lane_oe_n_o), .busy_i(busy_i), .mem_data_i(mem_data_i),
    .mem_rd_o(mem_rd_o), .mem_addr_o(mem_addr_o));
  flash_host_model h (.clk_i(clk_i), .dev_lane_i(lane_pin_o), .dev_oe_n_i(lane_oe_n_o),
    .sclk_o(sclk), .cs_n_o(cs_n), .lane_o(lane_w));
  function automatic logic [7:0] mdat(input logic [23:0] a);
    return a[7:0] ^ a[15:8] ^ a[23:16] ^ 8'h5A;
  endfunction : mdat
  function automatic logic [23:0] nxt(input logic [23:0] a, input logic [1:0] len,
                                      input logic wrap);
    logic [23:0] s;
    s = 24'(8 << len);
    return wrap ? ((a & ~(s - 24'h1)) | ((a + 24'h1) & (s - 24'h1))) : a + 24'h1;
  endfunction : nxt
  function automatic logic [31:0] xs(input logic [31:0] s);
    s ^= s << 13;
    s ^= s >> 17;
    s ^= s << 5;
    return s;
  endfunction : xs
  // array stand-in: byte valid only while the strobe stands, inverse otherwise
  always_comb mem_data_i = mem_rd_o ? mdat(mem_addr_o) : ~mdat(mem_addr_o);
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : print_verdict
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    tests_run++;
    if (got !== exp) begin
      failures++;
      $display("ERROR t=%0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask : chk
  task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d);
    int n;
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= a;
    wb_dat_i <= d;
    n = 0;
    @(posedge clk_i);
    while (wb_ack_o !== 1'b1) begin
      if (++n > 50) begin
        chk(0, 1, "ack timeout");
        print_verdict();
      end
      @(posedge clk_i);
    end
    q = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    @(posedge clk_i);
  endtask : wb
  task automatic rd(input logic [7:0] op, input logic [23:0] a, input int aw,
                    input int dum, input int dw, input int nb, input logic wrap,
                    input logic [1:0] len);
    logic [7:0] b;
    h.open();
    h.send({op, 24'h0}, 8, 1);
    if (aw == 1) h.send({a, 8'h0}, 24, 1);
    else h.send({a, 8'hF0}, 32, aw);
    h.idle(dum);
    for (int i = 0; i < nb; i++) begin
      h.recv(dw, b);
      chk(32'(b), 32'(mdat(a)), "data");
      a = nxt(a, len, wrap);
    end
    h.close();
    chk(32'(lane_oe_n_o), 32'hF, "release");
    $display("read %h done", op);
  endtask : rd
  task automatic refused(input logic [7:0] op);
    h.open();
    h.send({op, 24'h0}, 8, 1);
    h.send({seed[23:0], 8'h0}, 24, 1);
    repeat (10) begin
      h.idle(1);
      chk(32'(lane_oe_n_o), 32'hF, "undriven");
    end
    h.close();
    wb(1'b0, STATUS_OFS, 32'h0);
    chk(q & 32'h40, 32'h40, "ignored flag");
    $display("refused %h done", op);
  endtask : refused
  task automatic wrapset(input logic dis, input logic [1:0] len);
    h.open();
    h.send({OP_WRAP_SET, 24'h0}, 8, 1);
    h.send({24'h0, 1'b1, len, dis, 4'hF}, 32, 4);
    h.close();
    wb(1'b0, STATUS_OFS, 32'h0);
    chk(q & 32'h7, {29'h0, len, dis}, "wrap status");
    $display("wrap setup %0d %0d done", dis, len);
  endtask : wrapset
  task automatic status_rst(input string what);
    wb(1'b0, STATUS_OFS, 32'h0);
    chk(q & 32'h7, 32'h1, what);
    $display("%s done", what);
  endtask : status_rst
  // table of single and dual reads: opcode, address lanes, dummies, data lanes
  logic [7:0] ops [4] = '{OP_READ, OP_FAST, OP_DUAL_OUT, OP_DUAL_IO};
  int aws [4] = '{1, 1, 1, 2};
  int dms [4] = '{0, 8, 8, 0};
  int dws [4] = '{1, 1, 2, 2};
  initial begin
    repeat (5) @(posedge clk_i);
    rst_i <= 1'b0;
    repeat (6) @(posedge clk_i);
    status_rst("status reset");
    wb(1'b0, 8'h40, 32'h0);
    chk(q, 32'h0, "unmapped");
    for (int t = 0; t < 4; t++) begin
      seed = xs(seed);
      rd(ops[t], seed[23:0], aws[t], dms[t], dws[t], 3, 1'b0, 2'h0);
    end
    rd(OP_READ, 24'h0000FE, 1, 0, 1, 4, 1'b0, 2'h0);
    wb(1'b0, ADDR_OFS, 32'h0);
    chk(q, 32'h00000102, "address after four bytes");
    busy_i <= 1'b1;
    refused(OP_READ);
    busy_i <= 1'b0;
    refused(OP_QUAD_OUT);
    refused(OP_QUAD_IO);
    wb(1'b1, CTRL_OFS, 32'h1);
    wb(1'b0, CTRL_OFS, 32'h0);
    chk(q, 32'h1, "quad enable readback");
    seed = xs(seed);
    rd(OP_QUAD_OUT, seed[23:0], 1, 8, 4, 3, 1'b0, 2'h0);
    for (int l = 0; l < 4; l++) begin
      seed = xs(seed);
      wrapset(1'b0, 2'(l));
      rd(OP_QUAD_IO, {seed[23:3], 3'h6}, 4, 4, 4, (8 << l) + 3, 1'b1, 2'(l));
    end
    wrapset(1'b1, 2'h3);
    rd(OP_QUAD_IO, 24'h0010F6, 4, 4, 4, 12, 1'b0, 2'h0);
    wrapset(1'b0, 2'h1);
    wb(1'b1, CTRL_OFS, 32'h3);
    status_rst("soft reset");
    wb(1'b1, CTRL_OFS, 32'h1);
    rd(OP_QUAD_IO, 24'h0020FE, 4, 4, 4, 4, 1'b0, 2'h0);
    wrapset(1'b0, 2'h2);
    rst_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    repeat (6) @(posedge clk_i);
    status_rst("hard reset");
    print_verdict();
  end
endmodule : serial_flash_read_path_tb_top
